// [ifd_pkg.sv]
// constants and types for the instruction field decoder
// assumes 16-bit instruction words and a single core clock
package ifd_pkg;
  // ***************************************
  // word layout
  // ***************************************
  localparam int unsigned INSTR_W = 16;
  localparam int unsigned OPC6_HI = 15;
  localparam int unsigned OPC6_LO = 10;
  localparam int unsigned D_BIT = 9;
  localparam int unsigned A_BIT = 8;
  localparam int unsigned S_BIT = 8;
  localparam int unsigned FILE_HI = 7;
  localparam int unsigned FILE_LO = 0;
  localparam int unsigned OPC4_LO = 12;
  localparam int unsigned BIT_HI = 11;
  localparam int unsigned BIT_LO = 9;
  localparam int unsigned LIT_OPC_LO = 8;
  localparam int unsigned ADDR12_HI = 11;
  localparam int unsigned OFS_HI = 6;
  localparam int unsigned TBL_MODE_HI = 1;
  // ***************************************
  // widths
  // ***************************************
  localparam int unsigned ADDR12_W = 12;
  localparam int unsigned TARGET_W = 20;
  localparam int unsigned TBL_PTR_W = 21;
  localparam int unsigned BYTE_W = 8;
  localparam int unsigned OFS_W = 7;
  localparam int unsigned BANK_W = 4;
  // ***************************************
  // opcode patterns
  // ***************************************
  localparam logic [3:0] NIB_MOVE = 4'hC;
  localparam logic [3:0] NIB_SECOND = 4'hF;
  localparam logic [7:0] OPC_GOTO = 8'hEF;
  localparam logic [6:0] OPC_CALL = 7'h76;
  localparam logic [3:0] ACCESS_BANK = 4'h0;
  // ***************************************
  // reset values
  // ***************************************
  localparam logic [20:0] TBL_PTR_RST = 21'h000000;
  localparam logic [7:0] TBL_LATCH_RST = 8'h00;
  localparam logic [15:0] WORD_RST = 16'h0000;
  localparam logic [20:0] TBL_STEP = 21'h000001;
  // ***************************************
  // types
  // ***************************************
  typedef enum logic [1:0] {
    TBL_HOLD,
    TBL_POST_INC,
    TBL_POST_DEC,
    TBL_PRE_INC
  } ifd_tbl_mode_t;
  typedef enum logic {
    ST_FIRST,
    ST_SECOND
  } ifd_state_t;
endpackage

// [ifd_decoder.sv]
// instruction field decoder: splits instruction words into operand fields
// assumes fetch and execute run on clk_sys_i and feed it same-clock signals
//
// Summary of operation
// - byte ops give a six-bit opcode, destination bit 9, bank bit 8 and file address 7:0.
// - destination bit zero writes the working register, one writes the file register.
// - bank bit zero forces the access bank and ignores the bank select register.
// - the file-to-file move carries a 12-bit source in word one and destination in word two.
// - bit ops give opcode 15:12, bit position 11:9, bank bit 8 and file address 7:0.
// - literal ops give opcode 15:8 and an eight-bit constant in 7:0.
// - the fast select bit set saves or restores shadow registers, clear leaves them alone; here only a fast call raises shadow_update_o, nothing restores.
// - the table pointer is 21 bits into program memory, bytes go through an 8-bit latch.
// - indexed forms add 7-bit source and destination offsets to a pointer.
// - don't-care bits never change decoding and should be written as zero.
// - call and goto targets are 20 bits: 7:0 from word one, 19:8 from a 1111 second word.
// - a second word with top nibble 1111 executed alone acts as a no-operation.
module ifd_decoder #(
  parameter int unsigned TBL_PTR_W = ifd_pkg::TBL_PTR_W
) (
  // clock and reset
  input wire logic clk_sys_i,
  input wire logic resetn_i,
  // fetch side
  input wire logic [15:0] instr_i,
  input wire logic instr_valid_i,
  output logic need_second_o,
  output logic expect_second_o,
  // execute context
  input wire logic [3:0] bank_select_register_i,
  input wire logic [11:0] index_ptr_i,
  // byte and bit fields
  output logic [5:0] byte_opcode_o,
  output logic dest_is_file_o,
  output logic wr_working_o,
  output logic wr_file_o,
  output logic bank_from_bsr_o,
  output logic [7:0] file_addr_o,
  output logic [11:0] ram_addr_o,
  output logic [3:0] bit_opcode_o,
  output logic [2:0] bit_pos_o,
  // literal fields
  output logic [7:0] lit_opcode_o,
  output logic [7:0] literal_o,
  // indexed offsets
  output logic [11:0] idx_src_addr_o,
  output logic [11:0] idx_dst_addr_o,
  // two-word results
  output logic second_nop_o,
  output logic bad_second_o,
  output logic move_done_o,
  output logic [11:0] move_src_o,
  output logic [11:0] move_dst_o,
  output logic target_valid_o,
  output logic [19:0] target_o,
  output logic shadow_update_o,
  // table access
  input wire logic tbl_load_i,
  input wire logic [TBL_PTR_W-1:0] tbl_load_val_i,
  input wire logic tbl_step_i,
  input wire logic [7:0] tbl_rd_data_i,
  input wire logic tbl_rd_valid_i,
  output logic [1:0] tbl_mode_o,
  output logic [TBL_PTR_W-1:0] table_pointer_o,
  output logic [TBL_PTR_W-1:0] table_addr_o,
  output logic [7:0] table_byte_latch_o
);
  // ***************************************
  // two-word sequencing
  // ***************************************
  ifd_pkg::ifd_state_t state_q, state_d;
  logic [15:0] first_q, first_d;
  logic in_first;
  logic is_move, is_goto, is_call, two_word, second_ok;
  logic held_move, held_call, held_goto;
  logic [15:0] word1;

  assign in_first = (state_q == ifd_pkg::ST_FIRST);
  assign is_move = (instr_i[ifd_pkg::OPC6_HI:ifd_pkg::OPC4_LO] == ifd_pkg::NIB_MOVE);
  assign is_goto = (instr_i[ifd_pkg::OPC6_HI:ifd_pkg::LIT_OPC_LO] == ifd_pkg::OPC_GOTO);
  assign is_call = (instr_i[ifd_pkg::OPC6_HI:ifd_pkg::S_BIT+1] == ifd_pkg::OPC_CALL);
  assign two_word = is_move | is_goto | is_call;
  assign second_ok = (instr_i[ifd_pkg::OPC6_HI:ifd_pkg::OPC4_LO] == ifd_pkg::NIB_SECOND);
  assign held_move = (first_q[ifd_pkg::OPC6_HI:ifd_pkg::OPC4_LO] == ifd_pkg::NIB_MOVE);
  assign held_goto = (first_q[ifd_pkg::OPC6_HI:ifd_pkg::LIT_OPC_LO] == ifd_pkg::OPC_GOTO);
  assign held_call = (first_q[ifd_pkg::OPC6_HI:ifd_pkg::S_BIT+1] == ifd_pkg::OPC_CALL);
  assign word1 = in_first ? instr_i : first_q;

  assign need_second_o = instr_valid_i & in_first & two_word;
  assign expect_second_o = ~in_first;

  always_comb begin
    state_d = state_q;
    first_d = first_q;
    case (state_q)
      ifd_pkg::ST_FIRST: begin
        if (need_second_o) begin
          first_d = instr_i;
          state_d = ifd_pkg::ST_SECOND;
        end
      end
      ifd_pkg::ST_SECOND: begin
        if (instr_valid_i) begin
          state_d = ifd_pkg::ST_FIRST;
        end
      end
      default: begin
        state_d = ifd_pkg::ST_FIRST;
      end
    endcase
  end

  always_ff @(posedge clk_sys_i) begin
    if (!resetn_i) begin
      state_q <= ifd_pkg::ST_FIRST;
      first_q <= ifd_pkg::WORD_RST;
    end else begin
      state_q <= state_d;
      first_q <= first_d;
    end
  end

  // ***************************************
  // single-word fields
  // ***************************************
  // byte op fields
  assign byte_opcode_o = instr_i[ifd_pkg::OPC6_HI:ifd_pkg::OPC6_LO];
  assign dest_is_file_o = instr_i[ifd_pkg::D_BIT];
  assign bank_from_bsr_o = instr_i[ifd_pkg::A_BIT];
  assign file_addr_o = instr_i[ifd_pkg::FILE_HI:ifd_pkg::FILE_LO];
  assign wr_working_o = ~instr_i[ifd_pkg::D_BIT];
  assign wr_file_o = instr_i[ifd_pkg::D_BIT];
  assign ram_addr_o = instr_i[ifd_pkg::A_BIT] ? {bank_select_register_i, file_addr_o}
                                              : {ifd_pkg::ACCESS_BANK, file_addr_o};
  assign bit_opcode_o = instr_i[ifd_pkg::OPC6_HI:ifd_pkg::OPC4_LO];
  assign bit_pos_o = instr_i[ifd_pkg::BIT_HI:ifd_pkg::BIT_LO];
  assign lit_opcode_o = instr_i[ifd_pkg::OPC6_HI:ifd_pkg::LIT_OPC_LO];
  assign literal_o = instr_i[ifd_pkg::FILE_HI:ifd_pkg::FILE_LO];
  assign idx_src_addr_o = index_ptr_i + {5'h00, word1[ifd_pkg::OFS_HI:0]};
  assign idx_dst_addr_o = index_ptr_i + {5'h00, instr_i[ifd_pkg::OFS_HI:0]};

  // ***************************************
  // two-word fields
  // ***************************************
  // lone second word is a no-op
  assign second_nop_o = instr_valid_i & in_first & second_ok;
  assign bad_second_o = instr_valid_i & ~in_first & ~second_ok;
  assign move_src_o = first_q[ifd_pkg::ADDR12_HI:0];
  assign move_dst_o = instr_i[ifd_pkg::ADDR12_HI:0];
  assign move_done_o = instr_valid_i & ~in_first & second_ok & held_move;
  assign target_o = {instr_i[ifd_pkg::ADDR12_HI:0], first_q[ifd_pkg::FILE_HI:0]};
  assign target_valid_o = instr_valid_i & ~in_first & second_ok & (held_goto | held_call);
  // shadow update only on fast call
  assign shadow_update_o = target_valid_o & held_call & first_q[ifd_pkg::S_BIT];
  // unused bits are never decoded
  // only the fields above are looked at, so stray bits cannot change a decode

  // ***************************************
  // table pointer and byte latch
  // ***************************************
  logic [TBL_PTR_W-1:0] tptr_q, tptr_d;
  logic [7:0] tlat_q, tlat_d;
  logic [TBL_PTR_W-1:0] step;

  assign tbl_mode_o = instr_i[ifd_pkg::TBL_MODE_HI:0];
  assign step = TBL_PTR_W'(ifd_pkg::TBL_STEP);

  always_comb begin
    tptr_d = tptr_q;
    tlat_d = tlat_q;
    if (tbl_load_i) begin
      tptr_d = tbl_load_val_i;
    end else if (tbl_step_i) begin
      case (ifd_pkg::ifd_tbl_mode_t'(tbl_mode_o))
        ifd_pkg::TBL_POST_INC: tptr_d = tptr_q + step;
        ifd_pkg::TBL_POST_DEC: tptr_d = tptr_q - step;
        ifd_pkg::TBL_PRE_INC: tptr_d = tptr_q + step;
        default: tptr_d = tptr_q;
      endcase
    end
    if (tbl_rd_valid_i) begin
      tlat_d = tbl_rd_data_i;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (!resetn_i) begin
      tptr_q <= TBL_PTR_W'(ifd_pkg::TBL_PTR_RST);
      tlat_q <= ifd_pkg::TBL_LATCH_RST;
    end else begin
      tptr_q <= tptr_d;
      tlat_q <= tlat_d;
    end
  end

  // pre-increment addresses memory with the stepped value
  assign table_pointer_o = tptr_q;
  assign table_addr_o = (ifd_pkg::ifd_tbl_mode_t'(tbl_mode_o) == ifd_pkg::TBL_PRE_INC)
                        ? tptr_q + step : tptr_q;
  assign table_byte_latch_o = tlat_q;

  // ***************************************
  // assertions
  // ***************************************
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!resetn_i);

  property p_byte_fields;
    instr_valid_i |-> ({byte_opcode_o, dest_is_file_o, bank_from_bsr_o, file_addr_o} == instr_i);
  endproperty
  a_byte_fields: assert property (p_byte_fields) else $error("byte fields wrong");

  property p_dest;
    instr_valid_i |-> (wr_working_o != wr_file_o) && (wr_file_o == instr_i[9]);
  endproperty
  a_dest: assert property (p_dest) else $error("destination select wrong");

  property p_bank;
    instr_valid_i |-> (instr_i[8] ? ram_addr_o[11:8] == bank_select_register_i
                                  : ram_addr_o[11:8] == 4'h0) && ram_addr_o[7:0] == instr_i[7:0];
  endproperty
  a_bank: assert property (p_bank) else $error("bank addressing wrong");

  property p_move;
    (instr_valid_i && in_first && instr_i[15:12] == 4'hC) ##1
      (instr_valid_i && instr_i[15:12] == 4'hF)
      |-> move_done_o && move_src_o == $past(instr_i[11:0]) && move_dst_o == instr_i[11:0];
  endproperty
  a_move: assert property (p_move) else $error("move addresses wrong");

  property p_bit_fields;
    instr_valid_i |-> ({bit_opcode_o, bit_pos_o, bank_from_bsr_o, file_addr_o} == instr_i);
  endproperty
  a_bit_fields: assert property (p_bit_fields) else $error("bit fields wrong");

  property p_literal;
    instr_valid_i |-> ({lit_opcode_o, literal_o} == instr_i);
  endproperty
  a_literal: assert property (p_literal) else $error("literal fields wrong");

  property p_shadow;
    (instr_valid_i && in_first && instr_i[15:9] == 7'h76) ##1
      (instr_valid_i && instr_i[15:12] == 4'hF) |-> shadow_update_o == $past(instr_i[8]);
  endproperty
  a_shadow: assert property (p_shadow) else $error("shadow update wrong");

  property p_tbl_inc;
    (tbl_step_i && !tbl_load_i && tbl_mode_o == 2'h1) |=> tptr_q == $past(tptr_q) + step;
  endproperty
  a_tbl_inc: assert property (p_tbl_inc) else $error("table pointer not stepped");

  property p_index;
    (instr_valid_i && in_first) |-> idx_src_addr_o == index_ptr_i + {5'h00, instr_i[6:0]};
  endproperty
  a_index: assert property (p_index) else $error("indexed address wrong");

  property p_target;
    (instr_valid_i && in_first && instr_i[15:8] == 8'hEF) ##1
      (instr_valid_i && instr_i[15:12] == 4'hF)
      |-> target_valid_o && target_o == {instr_i[11:0], $past(instr_i[7:0])};
  endproperty
  a_target: assert property (p_target) else $error("branch target wrong");

  property p_lone_second;
    (instr_valid_i && in_first && instr_i[15:12] == 4'hF)
      |-> second_nop_o && !need_second_o ##1 in_first;
  endproperty
  a_lone_second: assert property (p_lone_second) else $error("lone second word not nop");

  property p_need_second;
    need_second_o |=> expect_second_o && first_q == $past(instr_i);
  endproperty
  a_need_second: assert property (p_need_second) else $error("second word not awaited");

  c_move: cover property (move_done_o);
  c_fast_call: cover property (shadow_update_o);
  c_lone_second: cover property (second_nop_o);
  c_tbl_pre: cover property (tbl_step_i && tbl_mode_o == 2'h3);
endmodule

// [ifd_fetch_model.sv]
// fetch stage model: hands instruction words to the decoder
// assumes put is called just after a falling clock edge
module ifd_fetch_model (
  // word stream
  output logic [15:0] instr_o,
  output logic instr_valid_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] last_q;
  initial begin
    last_q = 16'h0000;
    instr_o = 16'hFFFF;
    instr_valid_o = 1'b0;
  end
  // idle bus never repeats a stale word
  // second words carry top nibble 1111 from the caller
  task automatic put(input logic [15:0] w, input logic v);
    if (v) last_q = w;
    instr_o = v ? w : ~last_q;
    instr_valid_o = v;
  endtask
endmodule

// [tb_ifd_decoder.sv]
// testbench for the instruction field decoder
// assumes one 50 MHz clock and the fetch model driving words
module tb_ifd_decoder;
  timeunit 1ns;
  timeprecision 1ps;
  // ***************************************
  // signals and instances
  // ***************************************
  logic clk_sys_i = 1'b0;
  logic resetn_i = 1'b0;
  logic [15:0] instr_i;
  logic instr_valid_i, need_second_o, expect_second_o, dest_is_file_o, wr_working_o;
  logic wr_file_o, bank_from_bsr_o, second_nop_o, bad_second_o, move_done_o;
  logic target_valid_o, shadow_update_o, tbl_load_i, tbl_step_i, tbl_rd_valid_i;
  logic [3:0] bank_select_register_i, bit_opcode_o;
  logic [11:0] index_ptr_i, ram_addr_o, idx_src_addr_o, idx_dst_addr_o, move_src_o, move_dst_o;
  logic [5:0] byte_opcode_o;
  logic [7:0] file_addr_o, lit_opcode_o, literal_o, tbl_rd_data_i, table_byte_latch_o;
  logic [2:0] bit_pos_o;
  logic [19:0] target_o;
  logic [1:0] tbl_mode_o;
  logic [20:0] tbl_load_val_i, table_pointer_o, table_addr_o, ptr;
  logic [28:0] notes[$];
  int n_fail = 0;
  int num_checks = 0;
  always #10 clk_sys_i = ~clk_sys_i;
  ifd_fetch_model u_ifd_fetch_model (.instr_o(instr_i), .instr_valid_o(instr_valid_i));
  ifd_decoder u_ifd_decoder (.clk_sys_i, .resetn_i, .instr_i, .instr_valid_i, .need_second_o,
    .expect_second_o, .bank_select_register_i, .index_ptr_i, .byte_opcode_o, .dest_is_file_o,
    .wr_working_o, .wr_file_o, .bank_from_bsr_o, .file_addr_o, .ram_addr_o, .bit_opcode_o,
    .bit_pos_o, .lit_opcode_o, .literal_o, .idx_src_addr_o, .idx_dst_addr_o, .second_nop_o,
    .bad_second_o, .move_done_o, .move_src_o, .move_dst_o, .target_valid_o, .target_o,
    .shadow_update_o, .tbl_load_i, .tbl_load_val_i, .tbl_step_i, .tbl_rd_data_i, .tbl_rd_valid_i,
    .tbl_mode_o, .table_pointer_o, .table_addr_o, .table_byte_latch_o);
  // ***************************************
  // tasks
  // ***************************************
  task automatic chk(input string nm, input logic [47:0] e, input logic [47:0] g);
    num_checks++;
    if (g !== e) begin
      n_fail++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  // single-word decode with random context
  task automatic one(input logic [15:0] w);
    logic [3:0] b;
    logic [11:0] p;
    b = 4'($urandom);
    p = 12'($urandom);
    @(negedge clk_sys_i);
    bank_select_register_i = b;
    index_ptr_i = p;
    u_ifd_fetch_model.put(w, 1'b1);
    #5;
    chk("byte", {w[15:10], w[9:8], w[7:0]}, {byte_opcode_o, dest_is_file_o, bank_from_bsr_o, file_addr_o});
    chk("dest", {~w[9], w[9]}, {wr_working_o, wr_file_o});
    chk("ram", w[8] ? {b, w[7:0]} : {ifd_pkg::ACCESS_BANK, w[7:0]}, ram_addr_o);
    chk("bit", {w[15:12], w[11:9]}, {bit_opcode_o, bit_pos_o});
    chk("lit", w, {lit_opcode_o, literal_o});
    chk("idx", {2{p + {5'h00, w[6:0]}}}, {idx_src_addr_o, idx_dst_addr_o});
    chk("need", 1'b0, need_second_o);
  endtask
  // word, expected need flag, idle cycles after it
  task automatic send(input logic [15:0] w, input logic en, input int gap);
    @(negedge clk_sys_i);
    u_ifd_fetch_model.put(w, 1'b1);
    #5 chk("need", en, need_second_o);
    repeat (gap) begin
      @(negedge clk_sys_i);
      u_ifd_fetch_model.put(w, 1'b0);
      #5 chk("expect", en, expect_second_o);
    end
  endtask
  task automatic tbop(input logic ld, input logic st, input logic [1:0] m, input logic [20:0] v);
    logic [7:0] d;
    d = 8'($urandom);
    @(negedge clk_sys_i);
    tbl_load_i = ld;
    tbl_load_val_i = v;
    tbl_step_i = st;
    tbl_rd_valid_i = 1'b1;
    tbl_rd_data_i = d;
    u_ifd_fetch_model.put({14'h0380, m}, 1'b1);
    #5 chk("taddr", (m == 2'h3) ? 21'(ptr + 21'h000001) : ptr, table_addr_o);
    chk("tmode", m, tbl_mode_o);
    if (ld) ptr = v;
    else if (st && m != 2'h0) ptr = (m == 2'h2) ? ptr - 21'h000001 : ptr + 21'h000001;
    @(negedge clk_sys_i);
    tbl_load_i = 1'b0;
    tbl_step_i = 1'b0;
    tbl_rd_valid_i = 1'b0;
    #5 chk("tptr", {ptr, d}, {table_pointer_o, table_byte_latch_o});
  endtask
  // ***************************************
  // result watcher, stimulus, watchdog
  // ***************************************
  always begin
    @(negedge clk_sys_i);
    #5;
    if (resetn_i && (move_done_o | target_valid_o | second_nop_o | bad_second_o) === 1'b1) begin
      chk("result", (notes.size() > 0) ? notes.pop_front() : 29'h0, {move_done_o, target_valid_o,
        second_nop_o, bad_second_o, shadow_update_o, move_done_o ? {move_src_o, move_dst_o} :
        target_valid_o ? {4'h0, target_o} : 24'h0});
    end
  end
  initial begin
    repeat (20000) @(posedge clk_sys_i);
    n_fail++;
    $display("[FAIL] watchdog expected done seen hang");
    wrap_up();
  end
  initial begin
    bank_select_register_i = 4'h0;
    index_ptr_i = 12'h000;
    {tbl_load_i, tbl_step_i, tbl_rd_valid_i} = 3'h0;
    tbl_load_val_i = 21'h000000;
    tbl_rd_data_i = 8'h00;
    ptr = 21'h000000;
    void'($urandom(32'hd34f));
    repeat (3) @(negedge clk_sys_i);
    resetn_i = 1'b1;
    #5 chk("reset", 30'h0, {expect_second_o, table_pointer_o, table_byte_latch_o});
    // random words with bit 14 cleared so none opens a two-word pair
    repeat (40) one(16'($urandom) & 16'hBFFF);
    notes.push_back({5'b10000, 24'h123ABC});
    send(16'hC123, 1'b1, 2);
    send(16'hFABC, 1'b0, 1);
    // back-to-back pair so the move property sees both words
    notes.push_back({5'b10000, 24'h456789});
    send(16'hC456, 1'b1, 0);
    send(16'hF789, 1'b0, 0);
    notes.push_back({5'b01000, 24'h034512});
    send(16'hEF12, 1'b1, 0);
    send(16'hF345, 1'b0, 0);
    notes.push_back({5'b01001, 24'h0C49A});
    send(16'hED9A, 1'b1, 0);
    send(16'hF0C4, 1'b0, 0);
    notes.push_back({5'b01000, 24'h0FFF55});
    send(16'hEC55, 1'b1, 1);
    send(16'hFFFF, 1'b0, 0);
    notes.push_back({5'b00100, 24'h0});
    send(16'hF777, 1'b0, 1);
    notes.push_back({5'b00010, 24'h0});
    send(16'hC001, 1'b1, 0);
    send(16'h1234, 1'b0, 1);
    tbop(1'b1, 1'b1, 2'h1, 21'($urandom));
    for (int m = 0; m < 4; m++) tbop(1'b0, 1'b1, 2'(m), 21'h0);
    tbop(1'b1, 1'b0, 2'h3, 21'h1FFFFF);
    tbop(1'b0, 1'b1, 2'h3, 21'h0);
    for (int i = 0; i < 20 && notes.size() > 0; i++) @(negedge clk_sys_i);
    chk("pending", 32'h0, notes.size());
    wrap_up();
  end
endmodule
